//--- core/tsc_params.svh
`ifndef TSC_PARAMS_SVH
`define TSC_PARAMS_SVH

// Clock and burst timing
`define TSC_CLK_HZ          10000000
`define TSC_BURST_MAX_HZ    1200
`define TSC_BURST_BASE_CYC  ((`TSC_CLK_HZ + `TSC_BURST_MAX_HZ - 1) / `TSC_BURST_MAX_HZ)

// Metronome resolution: sub-ticks per beat and per MIDI timing byte
`define TSC_TICKS_LAST      8'hBF
`define TSC_MIDI_STEP       10'h008

// Settings word field positions
`define TSC_CFG_IN_RATIO    2:0
`define TSC_CFG_IN_FALL     3
`define TSC_CFG_THRESH_HI   4
`define TSC_CFG_OUT_RATIO   7:5
`define TSC_CFG_OUT_FALL    8
`define TSC_CFG_BURST       11:9

// Reset values and valid mode range
`define TSC_CFG_RESET       12'h042
`define TSC_MODE_RESET      4'h1
`define TSC_MODE_FIRST      4'h1
`define TSC_MODE_LAST       4'hC

`endif

//--- core/tsc_pkg.sv
package tsc_pkg;

  // Output pulse emitter states
  typedef enum logic [2:0] {
    EM_IDLE = 3'h1,
    EM_HIGH = 3'h2,
    EM_LOW  = 3'h4
  } tsc_emit_t;

  // Whole state of the reference-clock core
  typedef struct packed {
    logic        loaded;
    logic [11:0] cfg;
    logic        nv_we;
    logic [3:0]  mode;
    logic [15:0] tdiv;
    logic [9:0]  pend;
    logic [7:0]  pos;
    logic [7:0]  owed;
    tsc_emit_t   est;
    logic [16:0] ecnt;
    logic        tog_q;
    logic        sout;
    logic        mclk;
    logic        mstart;
    logic        mstop;
    logic        sstart;
    logic        sstop;
    logic        beat;
  } tsc_core_t;

  // Whole state of the link-side edge detector
  typedef struct packed {
    logic primed;
    logic prev;
    logic tog;
  } tsc_link_t;

endpackage

//--- core/tsc_link_if.sv
`timescale 1ns/1ps
`default_nettype none

// Signals between the core and the link-side receiver
interface tsc_link_if;
  logic edge_fall;
  logic pulse_tog;
  modport core (output edge_fall, input pulse_tog);
  modport link (input edge_fall, output pulse_tog);
endinterface

`default_nettype wire

//--- core/tsc_sync2.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser, W independent levels
module tsc_sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } tsc_sync_t;

  tsc_sync_t r_reg;
  tsc_sync_t r_next;

  // First stage feeds only the second
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = d;
    r_next.s2 = r_reg.s1;
  end

  always_ff @(posedge clk) begin
    r_reg <= r_next;
  end

  assign q = r_reg.s2;

endmodule

`default_nettype wire

//--- core/tsc_link_rx.sv
`timescale 1ns/1ps
`default_nettype none

// Samples the pulse input on the link clock and reports each active edge as a toggle
module tsc_link_rx
  import tsc_pkg::*;
(
  input  wire logic link_clk,
  input  wire logic rst,
  input  wire logic sync_in,
  tsc_link_if.link  lk
);

  logic [2:0] sy;
  logic       rst_l;
  logic       pin_s;
  logic       fall_s;
  logic       hit;
  tsc_link_t  r_reg;
  tsc_link_t  r_next;

  // Reset, pin and edge select brought into the link domain
  tsc_sync2 #(.W(3)) u_sy (
    .clk (link_clk),
    .d   ({rst, sync_in, lk.edge_fall}),
    .q   (sy)
  );

  assign rst_l  = sy[2];
  assign pin_s  = sy[1];
  assign fall_s = sy[0];

  // R3: edge polarity select
  assign hit = r_reg.primed & (fall_s ? (r_reg.prev & ~pin_s) : (~r_reg.prev & pin_s));

  always_comb begin
    r_next        = r_reg;
    r_next.primed = 1'b1;
    r_next.prev   = pin_s;
    if (hit) begin
      r_next.tog = ~r_reg.tog;
    end
  end

  always_ff @(posedge link_clk) begin
    if (rst_l) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lk.pulse_tog = r_reg.tog;

endmodule

`default_nettype wire

//--- core/tsc_tempo_sync.sv
`timescale 1ns/1ps
`include "tsc_params.svh"
`default_nettype none

// Function
// R1: Slaved to pulse input, count 12/24/48/96/192 pulses per beat.
// R2: Pulse output runs at its own 12/24/48/96/192 per beat.
// R3: Input counts on rising edge, or falling edge when select set.
// R4: Hold threshold select: zero-volt symmetric or fixed 1.5 V.
// R5: Square wave output; polarity bit picks which edge marks a clock.
// R6: Phase jump from footswitch emits catch-up burst of output pulses.
// R7: Burst rate limited to 1200/600/400/300/200/150 Hz.
// R8: Input, output and burst settings kept in non-volatile storage.
// R9: Mode 1 runs internal tempo only, no outputs, externals ignored.
// R10: Modes 2-4 master: pulse out, MIDI timing, or both.
// R11: Modes 5-8 follow pulse input, adding pulse, MIDI, or both.
// R12: Slaved pulse input converted to differing output ratio.
// R13: Modes 9-12 follow MIDI timing, adding pulse, relay, or both.
// R14: Mode not retained; power-on selects mode 1.
// R15: No output pulses while the metronome is stopped.
// R16: Start/stop sent only with MIDI clock out, obeyed only with MIDI in.
// R17: External master supplies configured edges per beat on configured polarity.
// R18: Steady output pulses spaced evenly, first aligned to the beat.
module tsc_tempo_sync
  import tsc_pkg::*;
#(
  parameter int unsigned BURST_BASE_CYC = `TSC_BURST_BASE_CYC
) (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        link_clk,
  input  wire logic        sync_in,
  output logic             sync_out,
  output logic             thresh_hi_sel,
  input  wire logic        cfg_we,
  input  wire logic [11:0] cfg_wdata,
  input  wire logic [11:0] nv_rdata,
  output logic      [11:0] nv_wdata,
  output logic             nv_we,
  input  wire logic        mode_we,
  input  wire logic [3:0]  mode_wdata,
  output logic      [3:0]  mode,
  input  wire logic        run,
  input  wire logic [15:0] tempo_period,
  input  wire logic        jump_req,
  input  wire logic [7:0]  jump_ticks,
  input  wire logic        midi_clk_in,
  input  wire logic        midi_start_in,
  input  wire logic        midi_stop_in,
  input  wire logic        seq_start_req,
  input  wire logic        seq_stop_req,
  output logic             midi_clk_out,
  output logic             midi_start_out,
  output logic             midi_stop_out,
  output logic             seq_start,
  output logic             seq_stop,
  output logic             beat
);

  tsc_core_t   r_reg;
  tsc_core_t   r_next;
  tsc_link_if  lk ();
  logic        tog_s;
  logic        src_int;
  logic        src_sync;
  logic        src_midi;
  logic        so_en;
  logic        mo_en;
  logic [4:0]  in_step;
  logic [4:0]  out_step;
  logic [3:0]  burst_mult;
  logic [16:0] half_cyc;
  logic        tick;
  logic        sync_ev;
  logic        midi_ev;
  logic [9:0]  add;
  logic        take;
  logic [7:0]  pos_n;
  logic        owe_inc;
  logic        owe_dec;
  logic        lvl;

  // Sub-ticks (of 192 per beat) carried by one pulse at a ratio code
  function automatic logic [4:0] ratio_step(input logic [2:0] code);
    logic [4:0] s;
    s = 5'h10;
    unique case (code)
      3'h0: s = 5'h10;
      3'h1: s = 5'h08;
      3'h2: s = 5'h04;
      3'h3: s = 5'h02;
      3'h4: s = 5'h01;
      default: s = 5'h10;
    endcase
    return s;
  endfunction

  // Burst period multiple of the 1200 Hz period
  function automatic logic [3:0] burst_div(input logic [2:0] code);
    logic [3:0] m;
    m = 4'h1;
    unique case (code)
      3'h0: m = 4'h1;
      3'h1: m = 4'h2;
      3'h2: m = 4'h3;
      3'h3: m = 4'h4;
      3'h4: m = 4'h6;
      3'h5: m = 4'h8;
      default: m = 4'h1;
    endcase
    return m;
  endfunction

  // Link-side receiver and its toggle crossing
  tsc_link_rx u_rx (
    .link_clk (link_clk),
    .rst      (rst),
    .sync_in  (sync_in),
    .lk       (lk.link)
  );

  // R3: edge select handed to the link side
  assign lk.edge_fall = r_reg.cfg[`TSC_CFG_IN_FALL];

  tsc_sync2 #(.W(1)) u_tog (
    .clk (ref_clk),
    .d   (lk.pulse_tog),
    .q   (tog_s)
  );

  // R9 R10 R11 R13: mode decode into sources and outputs
  always_comb begin
    src_int  = (r_reg.mode >= 4'h1) && (r_reg.mode <= 4'h4);
    src_sync = (r_reg.mode >= 4'h5) && (r_reg.mode <= 4'h8);
    src_midi = (r_reg.mode >= 4'h9) && (r_reg.mode <= 4'hC);
    so_en    = (r_reg.mode != 4'h0) && !r_reg.mode[0];
    mo_en    = (r_reg.mode == 4'h3) || (r_reg.mode == 4'h4) ||
               (r_reg.mode == 4'h7) || (r_reg.mode == 4'h8) ||
               (r_reg.mode == 4'hB) || (r_reg.mode == 4'hC);
  end

  // R1 R2 R7: step sizes and burst half period
  assign in_step    = ratio_step(r_reg.cfg[`TSC_CFG_IN_RATIO]);
  assign out_step   = ratio_step(r_reg.cfg[`TSC_CFG_OUT_RATIO]);
  assign burst_mult = burst_div(r_reg.cfg[`TSC_CFG_BURST]);
  assign half_cyc   = 17'((BURST_BASE_CYC * burst_mult) >> 1);

  // Tick sources feeding the pending count
  always_comb begin
    tick    = src_int && run && ({1'b0, r_reg.tdiv} + 17'h00001 >= {1'b0, tempo_period});
    // R1: each counted input pulse
    sync_ev = src_sync && run && (tog_s != r_reg.tog_q);
    midi_ev = src_midi && run && midi_clk_in;
    add     = {9'h000, tick};
    if (sync_ev) begin
      add = add + {5'h00, in_step};
    end
    if (midi_ev) begin
      add = add + `TSC_MIDI_STEP;
    end
    // R6: footswitch jump
    if (jump_req && run) begin
      add = add + {2'h0, jump_ticks};
    end
  end

  // R12 R18: consume one sub-tick per cycle, owe a pulse at each output step
  always_comb begin
    take    = (r_reg.pend != 10'h000);
    pos_n   = (r_reg.pos == `TSC_TICKS_LAST) ? 8'h00 : r_reg.pos + 8'h01;
    owe_inc = take && so_en && ((pos_n & {3'h0, out_step - 5'h01}) == 8'h00);
    owe_dec = so_en && (r_reg.est == EM_IDLE) && (r_reg.owed != 8'h00);
  end

  always_comb begin
    r_next        = r_reg;
    r_next.nv_we  = 1'b0;
    r_next.mclk   = 1'b0;
    r_next.mstart = 1'b0;
    r_next.mstop  = 1'b0;
    r_next.sstart = 1'b0;
    r_next.sstop  = 1'b0;
    r_next.beat   = 1'b0;
    r_next.tog_q  = tog_s;
    lvl           = 1'b0;

    // R8: settings restored once after reset, stored on change
    if (!r_reg.loaded) begin
      r_next.loaded = 1'b1;
      r_next.cfg    = nv_rdata;
    end else if (cfg_we) begin
      r_next.cfg   = cfg_wdata;
      r_next.nv_we = 1'b1;
    end

    // Mode change; codes outside 1..12 are ignored
    if (mode_we && (mode_wdata >= `TSC_MODE_FIRST) && (mode_wdata <= `TSC_MODE_LAST)) begin
      r_next.mode = mode_wdata;
    end

    // Internal tempo divider
    if (src_int && run) begin
      r_next.tdiv = tick ? 16'h0000 : r_reg.tdiv + 16'h0001;
    end

    r_next.pend = r_reg.pend + add - {9'h000, take};
    if (take) begin
      r_next.pos  = pos_n;
      r_next.beat = (pos_n == 8'h00);
      // R10 R11: MIDI timing from own beat position
      if (mo_en && !src_midi && (pos_n[2:0] == 3'h0)) begin
        r_next.mclk = 1'b1;
      end
    end

    // R13: relay of received timing bytes
    if (mo_en && src_midi && midi_clk_in) begin
      r_next.mclk = 1'b1;
    end

    r_next.owed = r_reg.owed + {7'h00, owe_inc} - {7'h00, owe_dec};

    // R6 R7: emitter, each pulse high then low for half the burst period
    unique case (r_reg.est)
      EM_IDLE: begin
        if (owe_dec) begin
          r_next.est  = EM_HIGH;
          r_next.ecnt = half_cyc - 17'h00001;
          lvl         = 1'b1;
        end
      end
      EM_HIGH: begin
        lvl = 1'b1;
        if (r_reg.ecnt == 17'h00000) begin
          r_next.est  = EM_LOW;
          r_next.ecnt = half_cyc - 17'h00001;
          lvl         = 1'b0;
        end else begin
          r_next.ecnt = r_reg.ecnt - 17'h00001;
        end
      end
      EM_LOW: begin
        if (r_reg.ecnt == 17'h00000) begin
          r_next.est = EM_IDLE;
        end else begin
          r_next.ecnt = r_reg.ecnt - 17'h00001;
        end
      end
      default: begin
        r_next.est = EM_IDLE;
      end
    endcase

    // R15: stopped metronome holds position at the beat and emits no pulses; received timing bytes are still relayed
    if (!run) begin
      r_next.tdiv = 16'h0000;
      r_next.pend = 10'h000;
      r_next.pos  = 8'h00;
      r_next.owed = 8'h00;
      r_next.est  = EM_IDLE;
      r_next.ecnt = 17'h00000;
      r_next.mclk = mo_en && src_midi && midi_clk_in;
      r_next.beat = 1'b0;
      lvl         = 1'b0;
    end

    // R5: polarity applied to the square wave
    r_next.sout = lvl ^ r_next.cfg[`TSC_CFG_OUT_FALL];

    // R16: start and stop gated by MIDI clock direction
    r_next.mstart = mo_en && seq_start_req;
    r_next.mstop  = mo_en && seq_stop_req;
    r_next.sstart = src_midi && midi_start_in;
    r_next.sstop  = src_midi && midi_stop_in;
  end

  // R14: mode returns to internal-only at every reset
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      r_reg      <= '0;
      r_reg.cfg  <= `TSC_CFG_RESET;
      r_reg.mode <= `TSC_MODE_RESET;
      r_reg.est  <= EM_IDLE;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs straight from state
  assign sync_out       = r_reg.sout;
  // R4: threshold select drives the input detector
  assign thresh_hi_sel  = r_reg.cfg[`TSC_CFG_THRESH_HI];
  assign nv_wdata       = r_reg.cfg;
  assign nv_we          = r_reg.nv_we;
  assign mode           = r_reg.mode;
  assign midi_clk_out   = r_reg.mclk;
  assign midi_start_out = r_reg.mstart;
  assign midi_stop_out  = r_reg.mstop;
  assign seq_start      = r_reg.sstart;
  assign seq_stop       = r_reg.sstop;
  assign beat           = r_reg.beat;

endmodule

`default_nettype wire

//--- sim/tsc_tempo_sync_monitor.sv
`timescale 1ns/1ps
`default_nettype none

// Port-level checks of the tempo sync core
module tsc_tempo_sync_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        cfg_we,
  input wire logic [11:0] cfg_wdata,
  input wire logic [11:0] nv_wdata,
  input wire logic        nv_we,
  input wire logic        mode_we,
  input wire logic [3:0]  mode_wdata,
  input wire logic [3:0]  mode,
  input wire logic        run,
  input wire logic        sync_out,
  input wire logic        midi_clk_in,
  input wire logic        midi_clk_out,
  input wire logic        seq_start_req,
  input wire logic        midi_start_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  a_settings_kept: assert property (cfg_we |=> nv_we && nv_wdata == $past(cfg_wdata))
    else $error("settings word not stored");
  a_mode_taken: assert property (mode_we && mode_wdata inside {[4'h1:4'hC]} |=> mode == $past(mode_wdata))
    else $error("mode not taken");
  a_mode_refused: assert property (mode_we && !(mode_wdata inside {[4'h1:4'hC]}) |=> $stable(mode))
    else $error("bad mode taken");
  a_mode_power_on: assert property ($fell(rst) |-> mode == 4'h1)
    else $error("mode not 1 after reset");
  a_mode1_quiet: assert property ($past(mode) == 4'h1 |-> !midi_clk_out && !midi_start_out)
    else $error("output in internal mode");
  a_start_sent: assert property (
    midi_start_out == $past(seq_start_req && mode inside {4'h3, 4'h4, 4'h7, 4'h8, 4'hB, 4'hC}))
    else $error("start message wrong");
  a_clock_relay: assert property (midi_clk_in && mode inside {4'hB, 4'hC} |=> midi_clk_out)
    else $error("timing byte not relayed");
  a_idle_level: assert property (
    !run && !$past(run) && !$past(run, 2) && $stable(nv_wdata) |-> sync_out == nv_wdata[8])
    else $error("pulse while stopped");
endmodule

bind tsc_tempo_sync tsc_tempo_sync_monitor u_mon (
  .ref_clk, .rst, .cfg_we, .cfg_wdata, .nv_wdata, .nv_we, .mode_we, .mode_wdata,
  .mode, .run, .sync_out, .midi_clk_in, .midi_clk_out, .seq_start_req, .midi_start_out
);

`default_nettype wire

//--- sim/tsc_drum_model.sv
`timescale 1ns/1ps
`default_nettype none

// Drum machine clock port: steady pulse source and output edge counter
module tsc_drum_model (
  input  wire logic ref_clk,
  input  wire logic en,
  input  wire logic in_fall,
  input  wire logic out_fall,
  input  wire logic sync_out,
  output logic      sync_in,
  output int        out_edges
);
  logic [3:0] ph_reg;
  logic       so_reg;

  initial begin
    ph_reg = 4'h0;
    so_reg = 1'b0;
    sync_in = 1'b0;
    out_edges = 0;
  end

  // one edge per slot
  // Active pulse every 16 cycles on the chosen edge, idle when stopped
  always @(posedge ref_clk) begin
    ph_reg <= ph_reg + 4'h1;
    sync_in <= in_fall ^ (en && ph_reg[3]);
  end

  // Count active edges of the core's output
  always @(posedge ref_clk) begin
    so_reg <= sync_out;
    if (sync_out !== so_reg && sync_out === !out_fall) out_edges <= out_edges + 1;
  end
endmodule

`default_nettype wire

//--- sim/tsc_tempo_sync_bench.sv
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the tempo sync core
module tsc_tempo_sync_bench;
  localparam logic [11:0] NV = 12'h02A;
  // Row: mode, settings, sync pulses per beat, MIDI clocks per beat
  localparam logic [31:0] ROWS [12] = '{32'h10420000, 32'h2082C000, 32'h30420018, 32'h41221818,
    32'h50400000, 32'h60020C00, 32'h70440018, 32'h80291818, 32'h90420000, 32'hA0221800,
    32'hB0420018, 32'hC0020C18};
  localparam logic [3:0] SS [3] = '{4'h1, 4'h3, 4'h9};
  logic        ref_clk, link_clk, rst, run, cfg_we, mode_we, midi_clk_in, sync_in;
  logic        seq_start_req, midi_start_in, sync_out, thresh_hi_sel, nv_we;
  logic        midi_clk_out, midi_start_out, seq_start, beat;
  logic        jump_req, midi_stop_out, seq_stop;
  logic [7:0]  jump_ticks;
  logic [11:0] cfg_wdata, nv_rdata, nv_wdata;
  logic [3:0]  mode_wdata, mode, mph;
  logic [31:0] r;
  int          out_edges, midi_cnt, s0, t0, gap, age, miscompares, checked;

  tsc_tempo_sync #(.BURST_BASE_CYC(8)) u_dut (
    .ref_clk, .rst, .link_clk, .sync_in, .sync_out, .thresh_hi_sel, .cfg_we, .cfg_wdata,
    .nv_rdata, .nv_wdata, .nv_we, .mode_we, .mode_wdata, .mode, .run,
    .tempo_period(16'h000A), .jump_req, .jump_ticks, .midi_clk_in,
    .midi_start_in, .midi_stop_in(midi_start_in), .seq_start_req, .seq_stop_req(seq_start_req),
    .midi_clk_out, .midi_start_out, .midi_stop_out, .seq_start, .seq_stop, .beat
  );
  tsc_drum_model u_drum (
    .ref_clk, .en(run), .in_fall(cfg_wdata[3]), .out_fall(cfg_wdata[8]), .sync_out,
    .sync_in, .out_edges
  );

  // Reference and link clocks, unrelated in phase
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end

  // Timing byte every 16 cycles while running; count MIDI clocks out
  always @(posedge ref_clk) begin
    mph <= mph + 4'h1;
    midi_clk_in <= run && mph == 4'hF;
    if (midi_clk_out === 1'b1) midi_cnt <= midi_cnt + 1;
  end

  task automatic check(input logic [11:0] got, input logic [11:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Wait at most 4000 cycles for a beat pulse
  task automatic wait_beat();
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (beat !== 1'b1 && n < 4000);
    if (n >= 4000) begin
      check(12'h000, 12'h001);
      stop_test();
    end
  endtask

  task automatic put_cfg(input logic [11:0] c);
    @(posedge ref_clk);
    cfg_wdata <= c;
    cfg_we <= 1'b1;
    @(posedge ref_clk);
    cfg_we <= 1'b0;
    @(negedge ref_clk);
    check(nv_we, 1'b1);
    check(nv_wdata, c);
    check(thresh_hi_sel, c[4]);
  endtask

  task automatic put_mode(input logic [3:0] m, input logic [3:0] e);
    @(posedge ref_clk);
    mode_wdata <= m;
    mode_we <= 1'b1;
    @(posedge ref_clk);
    mode_we <= 1'b0;
    @(negedge ref_clk);
    check(mode, e);
  endtask

  // Hold reset, check reset values, then the stored settings reload
  task automatic do_reset();
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (7) @(posedge ref_clk);
    @(negedge ref_clk);
    check(mode, 4'h1);
    check(nv_wdata, 12'h042);
    @(posedge ref_clk);
    rst <= 1'b0;
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    check(nv_wdata, NV);
  endtask

  initial begin
    rst = 1'b1;
    run = 1'b0;
    cfg_we = 1'b0;
    cfg_wdata = 12'h000;
    mode_we = 1'b0;
    mode_wdata = 4'h0;
    nv_rdata = NV;
    midi_clk_in = 1'b0;
    midi_start_in = 1'b0;
    seq_start_req = 1'b0;
    jump_req = 1'b0;
    jump_ticks = 8'h00;
    mph = 4'h0;
    midi_cnt = 0;
    miscompares = 0;
    checked = 0;
    do_reset();
    // Every mode: output pulses and MIDI clocks over one steady beat
    foreach (ROWS[i]) begin
      r = ROWS[i];
      put_cfg(r[27:16]);
      put_mode(r[31:28], r[31:28]);
      @(posedge ref_clk);
      run <= 1'b1;
      wait_beat();
      wait_beat();
      s0 = out_edges;
      t0 = midi_cnt;
      wait_beat();
      check(12'(out_edges - s0), r[15:8]);
      check(12'(midi_cnt - t0), r[7:0]);
      @(posedge ref_clk);
      run <= 1'b0;
      repeat (3) @(negedge ref_clk);
      check(sync_out, r[24]);
    end
    put_mode(4'h0, 4'hC);
    put_mode(4'hD, 4'hC);
    // Footswitch jump in mode 2: extra pulses, spaced no closer than the 600 Hz period
    put_cfg(12'h200);
    put_mode(4'h2, 4'h2);
    @(posedge ref_clk);
    run <= 1'b1;
    wait_beat();
    @(posedge ref_clk);
    jump_ticks <= 8'h60;
    jump_req <= 1'b1;
    @(posedge ref_clk);
    jump_req <= 1'b0;
    s0 = out_edges;
    t0 = out_edges;
    gap = 1000;
    age = 0;
    repeat (300) begin
      @(negedge ref_clk);
      age++;
      if (out_edges != t0) begin
        if (t0 != s0 && age < gap) begin
          gap = age;
        end
        age = 0;
        t0 = out_edges;
      end
    end
    check(12'(out_edges - s0 >= 6), 12'h001);
    check(12'(gap >= 16), 12'h001);
    @(posedge ref_clk);
    run <= 1'b0;
    repeat (3) @(negedge ref_clk);
    // Start messages pass only with MIDI clock out or in
    foreach (SS[i]) begin
      put_mode(SS[i], SS[i]);
      @(posedge ref_clk);
      seq_start_req <= 1'b1;
      midi_start_in <= 1'b1;
      @(posedge ref_clk);
      seq_start_req <= 1'b0;
      midi_start_in <= 1'b0;
      @(negedge ref_clk);
      check(midi_start_out, SS[i] == 4'h3);
      check(seq_start, SS[i] == 4'h9);
      check(midi_stop_out, SS[i] == 4'h3);
      check(seq_stop, SS[i] == 4'h9);
    end
    do_reset();
    stop_test();
  end
endmodule

`default_nettype wire
